// *** pkg/ddrmi_pkg.sv ***
// ****************************************************************
// Shared constants and carriers for the command decoder
// ****************************************************************
package ddrmi_pkg;

  // Pin and array geometry
  localparam int ADDR_W = 14;
  localparam int BA_W   = 2;
  localparam int NBANK  = 4;
  localparam int COL_W  = 10;
  localparam int MODE_W = 16;

  // Command codes as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;

  // Bank-address selects for the register writes
  localparam logic [1:0] BA_MR   = 2'h0;
  localparam logic [1:0] BA_EMR1 = 2'h1;

  // Operating mode word fields
  localparam int MR_BL_LSB  = 0;
  localparam int MR_BL_MSB  = 2;
  localparam int MR_BT      = 3;
  localparam int MR_CL_LSB  = 4;
  localparam int MR_CL_MSB  = 6;
  localparam int MR_DLLRST  = 8;
  localparam int MR_WR_LSB  = 9;
  localparam int MR_WR_MSB  = 11;
  localparam logic [2:0] BL_CODE8 = 3'h3;

  // Extended mode word 1 fields
  localparam int EMR_RTT0 = 2;
  localparam int EMR_RTT1 = 6;
  localparam int EMR_RDQS = 11;

  // Column address bit that requests auto precharge
  localparam int AP_BIT = 10;

  // Reset values
  localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] EMR_RST  = 14'h0000;

  // Clocks the DLL needs after its reset
  localparam logic [7:0] DLL_LOCK_CLK = 8'hC8;

  // Command pins sampled together
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } ddrmi_cmd_s;

  // One column beat of a burst
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [BA_W-1:0]   bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
    logic              last;
  } ddrmi_burst_s;

endpackage

// *** rtl/ddrmi_burst_seq.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Burst column sequencer
// ****************************************************************
module ddrmi_burst_seq
  import ddrmi_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  // Burst request
  input  wire logic              start_i,
  input  wire logic              write_i,
  input  wire logic [BA_W-1:0]   bank_i,
  input  wire logic [ADDR_W-1:0] row_i,
  input  wire logic [COL_W-1:0]  col_i,
  input  wire logic              bl8_i,
  input  wire logic              inter_i,
  // Beat output
  output ddrmi_burst_s           beat_o
);

  ddrmi_burst_s     beat_reg, beat_next;
  logic [2:0]       cnt_reg, cnt_next;
  logic [COL_W-1:0] base_reg, base_next;
  logic             bl8_reg, bl8_next;
  logic             inter_reg, inter_next;

  // Column of beat i; BL4 wraps inside the aligned group of four
  function automatic logic [COL_W-1:0] beat_col(
    input logic [COL_W-1:0] base,
    input logic [2:0]       idx,
    input logic             bl8,
    input logic             inter);
    logic [2:0] lo;
    lo = inter ? (base[2:0] ^ idx) : 3'(base[2:0] + idx);
    if (!bl8) begin
      lo[2] = base[2];
    end
    return {base[COL_W-1:3], lo};
  endfunction

  // A new command restarts the sequence even mid-burst
  always_comb begin
    beat_next  = beat_reg;
    cnt_next   = cnt_reg;
    base_next  = base_reg;
    bl8_next   = bl8_reg;
    inter_next = inter_reg;
    if (start_i) begin
      base_next       = col_i;
      bl8_next        = bl8_i;
      inter_next      = inter_i;
      cnt_next        = 3'h1;
      beat_next.valid = 1'b1;
      beat_next.write = write_i;
      beat_next.bank  = bank_i;
      beat_next.row   = row_i;
      beat_next.col   = col_i;                                 // [R6]
      beat_next.last  = 1'b0;
    end else if (beat_reg.valid && !beat_reg.last) begin
      beat_next.col  = beat_col(base_reg, cnt_reg, bl8_reg,
                                inter_reg);                   // [R4]
      beat_next.last = (cnt_reg == (bl8_reg ? 3'h7 : 3'h3));  // [R4]
      cnt_next       = 3'(cnt_reg + 3'h1);
    end else begin
      beat_next.valid = 1'b0;
      beat_next.last  = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      beat_reg  <= '0;
      cnt_reg   <= 3'h0;
      base_reg  <= '0;
      bl8_reg   <= 1'b0;
      inter_reg <= 1'b0;
    end else begin
      beat_reg  <= beat_next;
      cnt_reg   <= cnt_next;
      base_reg  <= base_next;
      bl8_reg   <= bl8_next;
      inter_reg <= inter_next;
    end
  end

  assign beat_o = beat_reg;

endmodule

// *** rtl/ddrmi_core.sv ***
`timescale 1ns/100ps
// Functional notes
// R1: Masked write beats are discarded per lane.
// R2: x8 DM pin is mask or read strobe.
// R3: ODT termination only when enabled in EMR1.
// R4: Bursts of four or eight in sequence.
// R5: Active opens bank and latches row.
// R6: Read/write gives start column and precharge.
// R7: Controller holds CKE and ODT low first.
// R8: Controller waits 200us then raises CKE.
// R9: Controller sends NOPs 400ns, then precharge-all.
// R10: Controller writes EMR2 then EMR3.
// R11: Controller writes EMR1 enabling the DLL.
// R12: Controller resets DLL via mode write A8.
// R13: Controller precharges all, two refreshes.
// R14: Controller rewrites mode word, A8 low.
// R15: Controller calibrates or sets default then exit.
// R16: Every register write carries all fields.
// R17: Mode write decoded only with banks idle.
// R18: Controller rewrites modes only banks precharged; t_refuse sends a mode write with bank 2 open.
// R19: Mode word fields decoded to block controls.
// R20: Controller keeps test-mode bit zero.
// R21: Controller keeps reserved bit A13 zero.
// R22: Controller rounds write recovery up.
// R23: Reads wait 200 clocks after DLL reset.
module ddrmi_core
  import ddrmi_pkg::*;
#(
  parameter int  LANES   = 1,
  parameter bit  X8_PART = 1'b1
)(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  // Command and address pins
  input  wire logic              cke_i,
  input  ddrmi_cmd_s             cmd_i,
  input  wire logic [BA_W-1:0]   ba_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  // Termination and write mask pins
  input  wire logic              odt_i,
  input  wire logic              beat_valid_i,
  input  wire logic [LANES-1:0]  beat_dm_i,
  // Mode controls
  output logic [MODE_W-1:0]      mode_word_o,
  output logic [2:0]             burst_len_code_o,
  output logic                   burst_inter_o,
  output logic [2:0]             cas_lat_o,
  output logic [2:0]             wr_rec_o,
  output logic                   dll_reset_o,
  output logic                   dll_ready_o,
  // Array and data path
  output logic [NBANK-1:0]       bank_open_o,
  output ddrmi_burst_s           burst_o,
  output logic [LANES-1:0]       beat_we_o,
  output logic                   term_en_o,
  output logic                   rdqs_en_o
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (LANES < 1 || LANES > 2) begin : g_bad_lanes
    $error("LANES must be 1 or 2");
  end
  if (X8_PART && LANES != 1) begin : g_bad_x8
    $error("x8 part has a single lane");
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [2:0] cmd_code;
  logic       cmd_go;
  logic       all_idle;
  logic       mrs_go;
  logic       act_go;
  logic       rw_go;
  logic       mask_on;
  logic       rtt_on;

  logic [MODE_W-1:0] mode_word_reg, mode_word_next;
  logic [ADDR_W-1:0] emr1_reg, emr1_next;
  logic [7:0]        dll_cnt_reg, dll_cnt_next;
  logic              dll_rst_reg, dll_rst_next;
  logic              dll_rdy_reg, dll_rdy_next;

  logic [NBANK-1:0]  open_reg, open_next;
  logic [ADDR_W-1:0] row_reg [NBANK];
  logic [ADDR_W-1:0] row_next [NBANK];
  logic              ap_reg, ap_next;
  logic [BA_W-1:0]   ap_bank_reg, ap_bank_next;

  logic [LANES-1:0]  we_reg, we_next;
  logic              term_reg, term_next;

  ddrmi_burst_s      beat;

  // Commands only count with CKE high and the chip selected
  assign cmd_code = {cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  assign cmd_go   = cke_i && !cmd_i.cs_n;
  assign all_idle = (open_reg == '0);
  assign mrs_go   = cmd_go && (cmd_code == CMD_MRS) && all_idle; // [R17]
  assign act_go   = cmd_go && (cmd_code == CMD_ACT) && !open_reg[ba_i];
  assign rw_go    = cmd_go && open_reg[ba_i] &&
                    (cmd_code == CMD_RD || cmd_code == CMD_WR);

  // ****************************************************************
  // Mode and extended mode words
  // ****************************************************************

  // Each write replaces the whole word, never a field subset
  always_comb begin
    mode_word_next = mode_word_reg;
    emr1_next      = emr1_reg;
    dll_rst_next   = 1'b0;
    dll_cnt_next   = (dll_cnt_reg != 8'h00) ?
                     8'(dll_cnt_reg - 8'h01) : dll_cnt_reg;
    if (mrs_go) begin
      case (ba_i)
        BA_MR: begin
          mode_word_next = {2'h0, addr_i};                    // [R19]
          if (addr_i[MR_DLLRST]) begin
            dll_cnt_next = DLL_LOCK_CLK;                      // [R23]
            dll_rst_next = 1'b1;
          end
        end
        BA_EMR1: begin
          emr1_next = addr_i;                                 // [R2]
        end
        default: begin
        end
      endcase
    end
    dll_rdy_next = (dll_cnt_next == 8'h00);
  end

  // Mode registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mode_word_reg <= MODE_RST;
      emr1_reg      <= EMR_RST;
      dll_cnt_reg   <= 8'h00;
      dll_rst_reg   <= 1'b0;
      dll_rdy_reg   <= 1'b0;
    end else begin
      mode_word_reg <= mode_word_next;
      emr1_reg      <= emr1_next;
      dll_cnt_reg   <= dll_cnt_next;
      dll_rst_reg   <= dll_rst_next;
      dll_rdy_reg   <= dll_rdy_next;
    end
  end

  // ****************************************************************
  // Bank state and burst launch
  // ****************************************************************

  // Auto precharge closes first so a same-cycle command wins
  always_comb begin
    open_next    = open_reg;
    row_next     = row_reg;
    ap_next      = ap_reg;
    ap_bank_next = ap_bank_reg;
    if (beat.valid && beat.last && ap_reg) begin
      open_next[ap_bank_reg] = 1'b0;                          // [R6]
      ap_next                = 1'b0;
    end
    if (act_go) begin
      open_next[ba_i] = 1'b1;                                 // [R5]
      row_next[ba_i]  = addr_i;                               // [R5]
    end
    if (rw_go) begin
      ap_next      = addr_i[AP_BIT];                          // [R6]
      ap_bank_next = ba_i;
    end
    if (cmd_go && cmd_code == CMD_PRE) begin
      if (addr_i[AP_BIT]) begin
        open_next = '0;
      end else begin
        open_next[ba_i] = 1'b0;
      end
    end
  end

  // Bank registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      open_reg    <= '0;
      row_reg     <= '{default: '0};
      ap_reg      <= 1'b0;
      ap_bank_reg <= '0;
    end else begin
      open_reg    <= open_next;
      row_reg     <= row_next;
      ap_reg      <= ap_next;
      ap_bank_reg <= ap_bank_next;
    end
  end

  // Column sequence for the launched burst
  ddrmi_burst_seq u_seq (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .start_i   (rw_go),
    .write_i   (cmd_code == CMD_WR),
    .bank_i    (ba_i),
    .row_i     (row_reg[ba_i]),
    .col_i     (addr_i[COL_W-1:0]),
    .bl8_i     (mode_word_reg[MR_BL_MSB:MR_BL_LSB] == BL_CODE8),
    .inter_i   (mode_word_reg[MR_BT]),
    .beat_o    (beat)
  );

  // ****************************************************************
  // Write mask and termination
  // ****************************************************************

  // On x8 with RDQS set in EMR1 the DM pin turns into a read strobe and stops masking
  assign mask_on = !(X8_PART && emr1_reg[EMR_RDQS]);          // [R2]
  assign rtt_on  = emr1_reg[EMR_RTT0] || emr1_reg[EMR_RTT1];

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_comb begin
      we_next[i] = beat_valid_i && !(beat_dm_i[i] && mask_on); // [R1]
    end
  end

  // ODT is ignored while the termination field is off
  always_comb begin
    term_next = odt_i && rtt_on;                              // [R3]
  end

  // Data path registers
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      we_reg   <= '0;
      term_reg <= 1'b0;
    end else begin
      we_reg   <= we_next;
      term_reg <= term_next;
    end
  end

  // Outputs, all taken from registers
  assign mode_word_o      = mode_word_reg;
  assign burst_len_code_o = mode_word_reg[MR_BL_MSB:MR_BL_LSB];
  assign burst_inter_o    = mode_word_reg[MR_BT];
  assign cas_lat_o        = mode_word_reg[MR_CL_MSB:MR_CL_LSB];
  assign wr_rec_o         = mode_word_reg[MR_WR_MSB:MR_WR_LSB];
  assign dll_reset_o      = dll_rst_reg;
  assign dll_ready_o      = dll_rdy_reg;
  assign bank_open_o      = open_reg;
  assign burst_o          = beat;
  assign beat_we_o        = we_reg;
  assign term_en_o        = term_reg;
  assign rdqs_en_o        = emr1_reg[EMR_RDQS];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_mask_drops_beat: assert property ( // [R1]
    beat_valid_i && beat_dm_i[0] && mask_on |=> !beat_we_o[0])
    else $error("masked beat was written");
  a_rdqs_no_mask: assert property ( // [R2]
    X8_PART && emr1_reg[EMR_RDQS] && beat_valid_i |=> beat_we_o[0])
    else $error("DM masked while in strobe mode");
  a_odt_gated: assert property ( // [R3]
    term_en_o |-> $past(odt_i) && $past(rtt_on))
    else $error("termination on without enable");
  a_burst_eight: assert property ( // [R4]
    rw_go && mode_word_reg[MR_BL_MSB:MR_BL_LSB] == BL_CODE8
    ##1 !rw_go [*7] |-> burst_o.valid ##1 burst_o.last)
    else $error("burst of eight wrong length");
  a_act_opens: assert property ( // [R5]
    act_go |=> bank_open_o[$past(ba_i)])
    else $error("activate did not open bank");
  a_start_col: assert property ( // [R6]
    rw_go |=> burst_o.valid && burst_o.col == $past(addr_i[COL_W-1:0]))
    else $error("burst start column wrong");
  a_mrs_idle: assert property ( // [R17]
    !$stable(mode_word_o) |-> $past(open_reg) == '0)
    else $error("mode word written with open bank");
  a_len_decode: assert property ( // [R19]
    mrs_go && ba_i == BA_MR |=> burst_len_code_o == $past(addr_i[2:0]))
    else $error("burst length field not captured");
  a_dll_wait: assert property ( // [R23]
    dll_reset_o |-> !dll_ready_o [*8])
    else $error("DLL ready too early");

  c_burst8:  cover property (burst_o.valid && burst_o.last &&
                             burst_len_code_o == BL_CODE8);
  c_mrs:     cover property (mrs_go && addr_i[MR_DLLRST]);
  c_masked:  cover property (beat_valid_i && !beat_we_next_any());
  c_term:    cover property (term_en_o);

  function automatic logic beat_we_next_any();
    return |we_next;
  endfunction

endmodule

// *** dv/ddrmi_ctrl_model.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Controller model driving the device pins
// ****************************************************************
module ddrmi_ctrl_model
  import ddrmi_pkg::*;
(
  // Clock
  input  wire logic              clk_sys_i,
  // Device pins
  output logic                   cke_o,
  output ddrmi_cmd_s             cmd_o,
  output logic [BA_W-1:0]        ba_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   odt_o,
  output logic                   beat_valid_o,
  output logic [0:0]             beat_dm_o
);
  // Power-up state: clock enable and termination held low
  initial begin
    cke_o        = 1'b0;
    odt_o        = 1'b0;
    cmd_o        = 4'hF;
    ba_o         = 2'h0;
    addr_o       = 14'h0000;
    beat_valid_o = 1'b0;
    beat_dm_o    = 1'b0;
  end

  // One command cycle; then the pins show the inverse, so a device
  // that reads a stale deselected bus cannot pass by luck
  task automatic issue(input logic [2:0] code, input logic [1:0] ba,
                       input logic [13:0] a);
    @(posedge clk_sys_i);
    #1;
    cmd_o  = {1'b0, code};
    ba_o   = ba;
    addr_o = a;
    @(posedge clk_sys_i);
    #1;
    cmd_o  = ~cmd_o;
    ba_o   = ~ba_o;
    addr_o = ~addr_o;
  endtask

  // Stable clock 200 us, then clock enable and 400 ns of deselects
  task automatic power_up();
    repeat (20000) @(posedge clk_sys_i);
    #1;
    cke_o = 1'b1;
    repeat (40) @(posedge clk_sys_i);
    issue(CMD_PRE, 2'h0, 14'h0400);
  endtask

  // One write beat with its mask; the mask flips once the beat is gone
  task automatic beat(input logic dm);
    @(posedge clk_sys_i);
    #1;
    beat_valid_o = 1'b1;
    beat_dm_o    = dm;
    @(posedge clk_sys_i);
    #1;
    beat_valid_o = 1'b0;
    beat_dm_o    = ~dm;
  endtask

  // Clock enable level, changed just after an edge
  task automatic set_cke(input logic v);
    @(posedge clk_sys_i);
    #1;
    cke_o = v;
  endtask

  // Termination request, held one sampling edge before returning
  task automatic set_odt(input logic v);
    @(posedge clk_sys_i);
    #1;
    odt_o = v;
    @(posedge clk_sys_i);
    #1;
  endtask
endmodule

// *** dv/test_ddrmi_core.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench for the command decoder
// ****************************************************************
module test_ddrmi_core
  import ddrmi_pkg::*;
;
  logic clk_sys_i;
  logic reset_i;
  logic cke, odt, bv;
  logic [0:0] dm, we;
  ddrmi_cmd_s cmd;
  ddrmi_burst_s burst;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [MODE_W-1:0] mode;
  logic [2:0] bl, cl, wr;
  logic bi, dll_rst, dll_rdy, term, rdqs;
  logic [NBANK-1:0] bopen;
  int miscompares = 0;
  int checks_done = 0;

  ddrmi_ctrl_model i_ctrl (.clk_sys_i(clk_sys_i), .cke_o(cke),
    .cmd_o(cmd), .ba_o(ba), .addr_o(addr), .odt_o(odt),
    .beat_valid_o(bv), .beat_dm_o(dm));

  ddrmi_core i_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .cke_i(cke),
    .cmd_i(cmd), .ba_i(ba), .addr_i(addr), .odt_i(odt),
    .beat_valid_i(bv), .beat_dm_i(dm), .mode_word_o(mode),
    .burst_len_code_o(bl), .burst_inter_o(bi), .cas_lat_o(cl),
    .wr_rec_o(wr), .dll_reset_o(dll_rst), .dll_ready_o(dll_rdy),
    .bank_open_o(bopen), .burst_o(burst), .beat_we_o(we),
    .term_en_o(term), .rdqs_en_o(rdqs));

  // 100 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic report_and_stop();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected decoded fields, worked out from the mode word layout
  function automatic logic [15:0] fields(input logic [15:0] m);
    return {6'h00, m[2:0], m[3], m[6:4], m[11:9]};
  endfunction

  task automatic check_mode(input logic [15:0] m);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(mode, m);
    chk({6'h00, bl, bi, cl, wr}, fields(m));
  endtask

  // Waits a bounded time for the first beat, then walks the burst
  task automatic check_burst(input logic w, input logic [1:0] bk,
    input logic [13:0] row, input logic [9:0] base, input int n);
    logic [9:0] col;
    int         k;
    k = 0;
    while (burst.valid !== 1'b1 && k < 4) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    if (k == 4) begin
      miscompares++;
      report_and_stop();
    end
    for (int i = 0; i < n; i++) begin
      if (bi === 1'b1) col = base ^ 10'(i);
      else if (n == 8) col = {base[9:3], base[2:0] + 3'(i)};
      else col = {base[9:2], base[1:0] + 2'(i)};
      chk(16'(burst.col), 16'(col));
      chk(16'({burst.write, burst.bank, burst.last}),
          16'({w, bk, i == n - 1}));
      chk(16'(burst.row), 16'(row));
      @(posedge clk_sys_i);
      #1;
    end
    chk(16'(burst.valid), 16'h0000);
  endtask

  // Full power-up; the DLL reset pulse and its 200-cycle lock window
  task automatic t_init();
    int k;
    i_ctrl.power_up();
    i_ctrl.issue(CMD_MRS, 2'h2, 14'h0000);
    i_ctrl.issue(CMD_MRS, 2'h3, 14'h0000);
    i_ctrl.issue(CMD_MRS, BA_EMR1, 14'h0004);
    i_ctrl.issue(CMD_MRS, BA_MR, 14'h0100);
    k = 0;
    while (dll_rst !== 1'b1 && k < 4) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    chk(16'(dll_rst), 16'h0001);
    k = 0;
    while (dll_rdy === 1'b0 && k < 300) begin
      @(posedge clk_sys_i);
      #1;
      k++;
    end
    chk(16'(k), 16'(DLL_LOCK_CLK));
    i_ctrl.issue(CMD_PRE, 2'h0, 14'h0400);
    i_ctrl.issue(CMD_REF, 2'h0, 14'h0000);
    i_ctrl.issue(CMD_REF, 2'h0, 14'h0000);
    i_ctrl.issue(CMD_MRS, BA_MR, 14'h0643);
    check_mode(16'h0643);
    i_ctrl.issue(CMD_MRS, BA_EMR1, 14'h0384);
    i_ctrl.issue(CMD_MRS, BA_EMR1, 14'h0004);
  endtask

  // Sequential eight-beat read with auto precharge from column 5
  task automatic t_read8();
    i_ctrl.issue(CMD_ACT, 2'h1, 14'h1ABC);
    i_ctrl.issue(CMD_RD, 2'h1, 14'h0405);
    check_burst(1'b0, 2'h1, 14'h1ABC, 10'h005, 8);
    @(posedge clk_sys_i);
    #1;
    chk(16'(bopen), 16'h0000);
  endtask

  // Mode write refused while a bank is open, taken once precharged
  task automatic t_refuse();
    i_ctrl.issue(CMD_ACT, 2'h2, 14'h0011);
    i_ctrl.issue(CMD_MRS, BA_MR, 14'h003A);
    check_mode(16'h0643);
    chk(16'(bopen), 16'h0004);
    i_ctrl.issue(CMD_PRE, 2'h2, 14'h0000);
    i_ctrl.issue(CMD_MRS, BA_MR, 14'h003A);
    check_mode(16'h003A);
  endtask

  // Interleaved four-beat write, bank left open without auto precharge
  task automatic t_write4();
    i_ctrl.issue(CMD_ACT, 2'h3, 14'h0055);
    i_ctrl.issue(CMD_WR, 2'h3, 14'h0006);
    check_burst(1'b1, 2'h3, 14'h0055, 10'h006, 4);
    chk(16'(bopen), 16'h0008);
    i_ctrl.issue(CMD_PRE, 2'h0, 14'h0400);
  endtask

  // Write mask, then the pin turned into a read strobe
  task automatic t_mask();
    i_ctrl.beat(1'b1);
    chk(16'(we), 16'h0000);
    i_ctrl.beat(1'b0);
    chk(16'(we), 16'h0001);
    i_ctrl.issue(CMD_MRS, BA_EMR1, 14'h0804);
    i_ctrl.beat(1'b1);
    chk(16'({rdqs, we}), 16'h0003);
  endtask

  // Termination follows its pin only while enabled
  task automatic t_odt();
    i_ctrl.set_odt(1'b1);
    chk(16'(term), 16'h0001);
    i_ctrl.issue(CMD_MRS, BA_EMR1, 14'h0000);
    i_ctrl.set_odt(1'b1);
    chk(16'(term), 16'h0000);
    i_ctrl.set_odt(1'b0);
  endtask

  // A register write with clock enable low must leave the strobe mode set
  task automatic t_cke();
    i_ctrl.set_cke(1'b0);
    i_ctrl.issue(CMD_MRS, BA_EMR1, 14'h0004);
    i_ctrl.set_cke(1'b1);
    chk(16'(rdqs), 16'h0001);
  endtask

  // Mid-run reset clears the decoded state; ready returns one edge later
  task automatic t_reset();
    @(posedge clk_sys_i);
    #1;
    reset_i = 1'b1;
    #1;
    chk(mode, 16'h0000);
    chk(16'({dll_rdy, term, rdqs, bopen}), 16'h0000);
    @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk(16'(dll_rdy), 16'h0001);
  endtask

  // Main sequence: reset for 16 cycles, then every scenario in turn
  initial begin
    reset_i = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    t_init();
    t_read8();
    t_refuse();
    t_write4();
    t_mask();
    t_cke();
    t_odt();
    t_reset();
    report_and_stop();
  end
endmodule
